// ---- rtl/rlepe_defs.svh ----
// Offsets, field positions, reset values and fixed codes of the packet encapsulator.
`ifndef RLEPE_DEFS_SVH
`define RLEPE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RLEPE_OFF_CTRL      8'h00
`define RLEPE_OFF_DEFPT     8'h04
`define RLEPE_OFF_COMP0     8'h08
`define RLEPE_OFF_STATUS    8'h18
`define RLEPE_OFF_SENT      8'h1c
`define RLEPE_OFF_DROP      8'h20

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RLEPE_CTRL_OMIT_BIT    0
`define RLEPE_CTRL_COMP_BIT    1
`define RLEPE_CTRL_CONCAT_BIT  2
`define RLEPE_CTRL_T0SZ_LSB    4
`define RLEPE_CTRL_T0SZ_MSB    7
`define RLEPE_COMP_VALID_BIT   24
`define RLEPE_COMP_CODE_LSB    16
`define RLEPE_COMP_CODE_MSB    23
`define RLEPE_T0SZ_RESET       4'h1
`define RLEPE_DEFPT_RESET      16'h0800

// ----------------------------------------------------------------------------
// Fixed codes and limits
// ----------------------------------------------------------------------------
`define RLEPE_SIG_PTYPE        16'h0082
`define RLEPE_SIG_CODE         8'h42
`define RLEPE_ESC_CODE         8'hff
`define RLEPE_MAX_TOTAL        14'h0fff
`define RLEPE_MAX_COMPLETE     14'h07ff
`define RLEPE_TAG_LEN          4'h1
`define RLEPE_LT1_LEN          4'h3

`endif

// ---- rtl/rlepe_pkg.sv ----
// Types shared by the packet encapsulator and its output buffer.
package rlepe_pkg;

  // ----------------------------------------------------------------------------
  // Packet descriptor presented with each higher layer packet
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ptype;
    logic        signalling;
    logic        vn_default;
    logic [7:0]  virtual_network_tag;
    logic        concat_hdr;
    logic        frag;
    logic [10:0] frag_len;
    logic [2:0]  frag_id;
    logic [11:0] ext_len;
    logic [11:0] pay_len;
    logic        pad_only;
  } rlepe_desc_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [15:0] ptype;
  } rlepe_comp_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rlepe_byte_type;

  typedef enum logic [2:0] {
    RLEPE_IDLE  = 3'b000,
    RLEPE_HEAD  = 3'b001,
    RLEPE_LABEL = 3'b010,
    RLEPE_PTYPE = 3'b011,
    RLEPE_BODY  = 3'b100,
    RLEPE_DROP  = 3'b101,
    RLEPE_PAD   = 3'b110
  } rlepe_fsm_type;

endpackage : rlepe_pkg

// ---- rtl/rlepe_encap.sv ----
// Packet encapsulator: label and protocol type coding, length check, header build, output FIFO.
//
// Function
// - Whole higher layer packet goes into the data field, never split or joined.
// - Drop packet whose encapsulated length would exceed 4095 bytes.
// - Send concatenation extension header only when receiver support is configured.
// - Extension headers pass through unchanged, fragmentable like the rest.
// - Label length: type 0 configurable (1 by hub), type 1 three, types 2/3 zero.
// - Signalling uses label type 3, fixed default 0x0082 or compressed 0x42.
// - Label types 0, 1, 2 share the configured default protocol type.
// - Non-default network uses type 0 with one-byte tag; default network type 2.
// - Omit protocol field and set absent flag when the type is the label type's default; type 0 only with a one-byte label.
// - Compression off: insert full two-byte type, high byte first, flag clear.
// - Compression on and table hit: insert one-byte code, flag clear.
// - Compression on, no hit: insert 0xff then full type, flag clear.
// - Total length is protocol field plus label, extension and payload lengths.
// - Total length field only in a start fragment, never in a complete packet.
// - Unused burst space is filled with padding bytes; no burst CRC.
`timescale 1ns/10ps
`default_nettype none
`include "rlepe_defs.svh"

// ----------------------------------------------------------------------------
// Output byte FIFO
// ----------------------------------------------------------------------------
module rlepe_fifo
  import rlepe_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wptr;
    logic [AW:0]                 rptr;
  } rlepe_fifo_state_type;

  rlepe_fifo_state_type fifo_reg;
  rlepe_fifo_state_type fifo_next;
  logic                 full;
  logic                 empty;

  assign empty     = (fifo_reg.wptr == fifo_reg.rptr);
  assign full      = (fifo_reg.wptr[AW] != fifo_reg.rptr[AW]) &&
                     (fifo_reg.wptr[AW-1:0] == fifo_reg.rptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = fifo_reg.mem[fifo_reg.rptr[AW-1:0]];

  always_comb begin
    fifo_next = fifo_reg;
    if (in_valid && !full) begin
      fifo_next.mem[fifo_reg.wptr[AW-1:0]] = in_data;
      fifo_next.wptr = fifo_reg.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      fifo_next.rptr = fifo_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

endmodule : rlepe_fifo

// ----------------------------------------------------------------------------
// Encapsulator top
// ----------------------------------------------------------------------------
module rlepe_encap
  import rlepe_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int COMP_N     = 4
) (
  input  wire logic           mclk,
  input  wire logic           reset_n,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [31:0]    reg_rdata,
  input  wire logic           desc_valid,
  output logic                desc_ready,
  input  wire rlepe_desc_type desc,
  input  wire logic           in_valid,
  output logic                in_ready,
  input  wire logic [7:0]     in_data,
  output logic                out_valid,
  input  wire logic           out_ready,
  output logic      [7:0]     out_data,
  output logic                out_last
);

  typedef struct packed {
    rlepe_fsm_type                   fsm;
    logic                            allow_omit;
    logic                            use_comp;
    logic                            concat_ok;
    logic [3:0]                      t0_size;
    logic [15:0]                     def_ptype;
    logic [COMP_N-1:0][24:0]         table_ent;
    logic [12:0]                     cnt;
    logic [13:0]                     rem;
    logic [3:0][7:0]                 hdr;
    logic [2:0]                      hdr_n;
    logic [3:0]                      lbl_n;
    logic                            lbl_tag;
    logic [7:0]                      tag;
    logic [2:0][7:0]                 pt;
    logic [1:0]                      pt_n;
    logic [12:0]                     body_n;
    logic [15:0]                     sent_cnt;
    logic [15:0]                     drop_cnt;
    logic [31:0]                     rdata;
  } rlepe_state_type;

  rlepe_state_type s_reg;
  rlepe_state_type s_next;
  logic            f_valid;
  logic            f_ready;
  rlepe_byte_type  f_data;
  rlepe_byte_type  f_out;

  // Sum of extension, payload, label and protocol field lengths at 14 bits.
  function automatic logic [13:0] rlepe_len14(input logic [11:0] a, input logic [11:0] b,
                                               input logic [3:0] c, input logic [1:0] d);
    rlepe_len14 = 14'(a) + 14'(b) + 14'(c) + 14'(d);
  endfunction : rlepe_len14

  assign desc_ready = (s_reg.fsm == RLEPE_IDLE);
  assign reg_rdata  = s_reg.rdata;
  assign out_data   = f_out.data;
  assign out_last   = f_out.last;

  always_comb begin
    logic [1:0]  lt;
    logic [15:0] dflt;
    logic        omit;
    logic        hit;
    logic [7:0]  code;
    logic [13:0] total;
    logic [12:0] body;
    logic        bad;
    lt       = 2'd0;
    dflt     = 16'h0;
    omit     = 1'b0;
    hit      = 1'b0;
    code     = 8'h0;
    total    = 14'h0;
    body     = 13'h0;
    bad      = 1'b0;
    s_next   = s_reg;
    f_valid  = 1'b0;
    f_data   = '0;
    in_ready = 1'b0;

    // ----------------------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------------------
    s_next.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `RLEPE_OFF_CTRL:   s_next.rdata = {24'h0, s_reg.t0_size, 1'b0, s_reg.concat_ok,
                                           s_reg.use_comp, s_reg.allow_omit};
        `RLEPE_OFF_DEFPT:  s_next.rdata = {16'h0, s_reg.def_ptype};
        `RLEPE_OFF_STATUS: s_next.rdata = {29'h0, s_reg.fsm};
        `RLEPE_OFF_SENT:   s_next.rdata = {16'h0, s_reg.sent_cnt};
        `RLEPE_OFF_DROP:   s_next.rdata = {16'h0, s_reg.drop_cnt};
        default: begin
          for (int i = 0; i < COMP_N; i++) begin
            if (reg_addr == `RLEPE_OFF_COMP0 + 8'(4 * i)) begin
              s_next.rdata = {7'h0, s_reg.table_ent[i]};
            end
          end
        end
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        `RLEPE_OFF_CTRL: begin
          s_next.allow_omit = reg_wdata[`RLEPE_CTRL_OMIT_BIT];
          s_next.use_comp   = reg_wdata[`RLEPE_CTRL_COMP_BIT];
          s_next.concat_ok  = reg_wdata[`RLEPE_CTRL_CONCAT_BIT];
          s_next.t0_size    = reg_wdata[`RLEPE_CTRL_T0SZ_MSB:`RLEPE_CTRL_T0SZ_LSB];
        end
        `RLEPE_OFF_DEFPT: s_next.def_ptype = reg_wdata[15:0];
        default: begin
          for (int i = 0; i < COMP_N; i++) begin
            if (reg_addr == `RLEPE_OFF_COMP0 + 8'(4 * i)) begin
              s_next.table_ent[i] = reg_wdata[24:0];
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------------------
    // Encapsulation sequence
    // ----------------------------------------------------------------------------
    case (s_reg.fsm)
      RLEPE_IDLE: begin
        if (desc_valid && desc.pad_only) begin
          s_next.cnt = 13'(desc.pay_len);
          if (desc.pay_len != 12'h0) begin
            s_next.fsm = RLEPE_PAD;
          end
        end else if (desc_valid) begin
          s_next.tag = desc.virtual_network_tag;
          if (desc.signalling) begin
            lt   = 2'd3;
            dflt = `RLEPE_SIG_PTYPE;
            s_next.lbl_n = 4'h0;
          end else if (desc.vn_default) begin
            lt   = 2'd2;
            dflt = s_reg.def_ptype;
            s_next.lbl_n = 4'h0;
          end else begin
            lt   = 2'd0;
            dflt = s_reg.def_ptype;
            s_next.lbl_n = s_reg.t0_size;
          end
          omit = s_reg.allow_omit && (desc.ptype == dflt) &&
                 (desc.signalling || desc.vn_default || s_reg.t0_size == `RLEPE_TAG_LEN);
          for (int i = 0; i < COMP_N; i++) begin
            if (s_reg.table_ent[i][`RLEPE_COMP_VALID_BIT] &&
                s_reg.table_ent[i][15:0] == desc.ptype && !hit) begin
              hit  = 1'b1;
              code = s_reg.table_ent[i][`RLEPE_COMP_CODE_MSB:`RLEPE_COMP_CODE_LSB];
            end
          end
          if (desc.signalling && desc.ptype == `RLEPE_SIG_PTYPE) begin
            hit  = 1'b1;
            code = `RLEPE_SIG_CODE;
          end
          if (omit) begin
            s_next.pt_n = 2'd0;
            s_next.pt   = '0;
          end else if (!s_reg.use_comp) begin
            s_next.pt_n = 2'd2;
            s_next.pt   = {desc.ptype, 8'h0};
          end else if (hit) begin
            s_next.pt_n = 2'd1;
            s_next.pt   = {code, 16'h0};
          end else begin
            s_next.pt_n = 2'd3;
            s_next.pt   = {`RLEPE_ESC_CODE, desc.ptype};
          end
          total = rlepe_len14(desc.ext_len, desc.pay_len, s_next.lbl_n, s_next.pt_n);
          body  = 13'(desc.ext_len) + 13'(desc.pay_len);
          bad = (total > `RLEPE_MAX_TOTAL) || (!desc.frag && total > `RLEPE_MAX_COMPLETE);
          bad = bad || (desc.concat_hdr && !s_reg.concat_ok);
          s_next.body_n = body;
          if (bad) begin
            s_next.drop_cnt = s_reg.drop_cnt + 16'h1;
            s_next.cnt      = body;
            if (body != 13'h0) begin
              s_next.fsm = RLEPE_DROP;
            end
          end else if (desc.frag) begin
            s_next.hdr   = {1'b1, 1'b0, desc.frag_len, desc.frag_id,
                            total[12:0], lt, omit};
            s_next.hdr_n = 3'd4;
            s_next.rem   = total + 14'd4;
            s_next.cnt   = 13'h0;
            s_next.fsm   = RLEPE_HEAD;
          end else begin
            s_next.hdr   = {1'b1, 1'b1, total[10:0], lt, omit, 16'h0};
            s_next.hdr_n = 3'd2;
            s_next.rem   = total + 14'd2;
            s_next.cnt   = 13'h0;
            s_next.fsm   = RLEPE_HEAD;
          end
        end
      end
      RLEPE_HEAD: begin
        f_valid = 1'b1;
        f_data  = '{data: s_reg.hdr[2'(3 - s_reg.cnt[1:0])], last: s_reg.rem == 14'h1};
        if (f_ready) begin
          s_next.rem = s_reg.rem - 14'h1;
          s_next.cnt = s_reg.cnt + 13'h1;
          if (s_reg.cnt == 13'(s_reg.hdr_n) - 13'h1) begin
            s_next.cnt = 13'h0;
            s_next.fsm = RLEPE_LABEL;
          end
        end
      end
      RLEPE_LABEL: begin
        if (s_reg.lbl_n == 4'h0) begin
          s_next.fsm = RLEPE_PTYPE;
        end else begin
          f_valid = 1'b1;
          f_data  = '{data: (s_reg.cnt == 13'h0) ? s_reg.tag : 8'h0,
                      last: s_reg.rem == 14'h1};
          if (f_ready) begin
            s_next.rem = s_reg.rem - 14'h1;
            s_next.cnt = s_reg.cnt + 13'h1;
            if (s_reg.cnt == 13'(s_reg.lbl_n) - 13'h1) begin
              s_next.cnt = 13'h0;
              s_next.fsm = RLEPE_PTYPE;
            end
          end
        end
      end
      RLEPE_PTYPE: begin
        if (s_reg.pt_n == 2'd0) begin
          s_next.fsm = RLEPE_BODY;
        end else begin
          f_valid = 1'b1;
          f_data  = '{data: s_reg.pt[2'(2 - s_reg.cnt[1:0])], last: s_reg.rem == 14'h1};
          if (f_ready) begin
            s_next.rem = s_reg.rem - 14'h1;
            s_next.cnt = s_reg.cnt + 13'h1;
            if (s_reg.cnt == 13'(s_reg.pt_n) - 13'h1) begin
              s_next.cnt = 13'h0;
              s_next.fsm = RLEPE_BODY;
            end
          end
        end
      end
      RLEPE_BODY: begin
        if (s_reg.body_n == 13'h0) begin
          s_next.sent_cnt = s_reg.sent_cnt + 16'h1;
          s_next.fsm      = RLEPE_IDLE;
        end else begin
          in_ready = f_ready;
          f_valid  = in_valid;
          f_data   = '{data: in_data, last: s_reg.rem == 14'h1};
          if (in_valid && f_ready) begin
            s_next.rem = s_reg.rem - 14'h1;
            s_next.cnt = s_reg.cnt + 13'h1;
            if (s_reg.cnt == s_reg.body_n - 13'h1) begin
              s_next.sent_cnt = s_reg.sent_cnt + 16'h1;
              s_next.fsm      = RLEPE_IDLE;
            end
          end
        end
      end
      RLEPE_DROP: begin
        in_ready = 1'b1;
        if (in_valid) begin
          s_next.cnt = s_reg.cnt - 13'h1;
          if (s_reg.cnt == 13'h1) begin
            s_next.fsm = RLEPE_IDLE;
          end
        end
      end
      RLEPE_PAD: begin
        f_valid = 1'b1;
        f_data  = '{data: 8'h0, last: s_reg.cnt == 13'h1};
        if (f_ready) begin
          s_next.cnt = s_reg.cnt - 13'h1;
          if (s_reg.cnt == 13'h1) begin
            s_next.fsm = RLEPE_IDLE;
          end
        end
      end
      default: s_next.fsm = RLEPE_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg           <= '0;
      s_reg.fsm       <= RLEPE_IDLE;
      s_reg.t0_size   <= `RLEPE_T0SZ_RESET;
      s_reg.def_ptype <= `RLEPE_DEFPT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // The buffer decouples the burst packer; when it fills, the sequence and the input stall.
  rlepe_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (f_out)
  );

endmodule : rlepe_encap
`default_nettype wire

// ---- verif/rlepe_encap_properties.sv ----
// Concurrent checks on the packet encapsulator ports, bound into the top module.
`timescale 1ns/10ps
`default_nettype none
module rlepe_encap_properties
  import rlepe_pkg::*;
(
  input wire logic           mclk,
  input wire logic           reset_n,
  input wire logic [7:0]     reg_addr,
  input wire logic [31:0]    reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [31:0]    reg_rdata,
  input wire logic           desc_valid,
  input wire logic           desc_ready,
  input wire rlepe_desc_type desc,
  input wire logic           in_valid,
  input wire logic           in_ready,
  input wire logic [7:0]     in_data,
  input wire logic           out_valid,
  input wire logic           out_ready,
  input wire logic [7:0]     out_data,
  input wire logic           out_last
);
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // The protocol field is unseen here, so only bodies that are too long on their own count.
  logic        took;
  logic [12:0] body_len;
  logic        too_long;
  assign took     = desc_valid && desc_ready;
  assign body_len = {1'b0, desc.ext_len} + {1'b0, desc.pay_len};
  assign too_long = !desc.pad_only && ((body_len > 13'h0fff) || (!desc.frag && body_len > 13'h07ff));
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output byte changed while stalled");
  chk_desc_busy: assert property (
    took |=> !desc_ready)
    else $error("second descriptor accepted during a packet");
  chk_idle_in: assert property (
    desc_ready |-> !in_ready)
    else $error("input byte taken with no packet open");
  chk_drop_quiet: assert property (
    took && too_long |=> !$rose(out_valid) [*8])
    else $error("dropped packet produced output");
  chk_drop_drain: assert property (
    took && too_long |-> ##[1:8] in_ready)
    else $error("dropped packet body not consumed");
  chk_defpt_back: assert property (
    reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
    |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("default protocol type not read back");
  chk_ctrl_back: assert property (
    reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00
    |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 2))
    else $error("label size not read back");
  chk_rdata_rest: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
endmodule : rlepe_encap_properties

bind rlepe_encap rlepe_encap_properties i_chk (.*);
`default_nettype wire

// ---- verif/rlepe_hub_rx.sv ----
// Hub-side receiver model: takes encapsulated bytes, promptly, slowly or not at all.
`timescale 1ns/10ps
`default_nettype none
module rlepe_hub_rx (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  input  wire logic       stall,
  input  wire logic       slow,
  output logic            out_ready,
  output logic            got,
  output logic [7:0]      got_data,
  output logic            got_last
);
  logic [1:0] pace_reg;
  // Slow mode takes one byte in four, so the encapsulator's buffer really backs up.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pace_reg  <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      pace_reg  <= pace_reg + 2'h1;
      out_ready <= !stall && (!slow || pace_reg == 2'h3);
    end
  end
  // bytes taken whole
  // No extension header is parsed, so none is ever discarded as unsupported.
  assign got      = out_valid && out_ready;
  assign got_data = out_data;
  assign got_last = out_last;
endmodule : rlepe_hub_rx
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the packet encapsulator with a hub receiver model.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rlepe_pkg::*;
;
  logic           mclk       = 1'b0;
  logic           reset_n    = 1'b0;
  logic [7:0]     reg_addr   = 8'h00;
  logic [31:0]    reg_wdata  = 32'h0;
  logic           reg_wr     = 1'b0;
  logic           reg_rd     = 1'b0;
  logic [31:0]    reg_rdata;
  logic           desc_valid = 1'b0;
  logic           desc_ready;
  rlepe_desc_type desc       = '0;
  logic           in_valid   = 1'b0;
  logic           in_ready;
  logic [7:0]     in_data    = 8'h00;
  logic           out_valid;
  logic           out_ready;
  logic [7:0]     out_data;
  logic           out_last;
  logic           stall      = 1'b0;
  logic           slow       = 1'b0;
  logic           got;
  logic [7:0]     got_data;
  logic           got_last;
  logic [8:0]     exq[$];
  logic [8:0]     rxq[$];
  int             error_cnt  = 0;
  int             num_checks = 0;
  int             cyc        = 0;

  always #50 mclk = ~mclk;

  rlepe_encap #(.FIFO_DEPTH(16), .COMP_N(4)) i_dut (.*);
  rlepe_hub_rx i_hub (.*);

  always @(posedge mclk) begin
    if (got) rxq.push_back({got_last, got_data});
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, v);
  endtask : rd

  function automatic rlepe_desc_type mk(input logic [15:0] pt, input logic [1:0] sv,
      input logic [7:0] tag, input logic [2:0] cf, input logic [13:0] fl,
      input logic [11:0] ext, input logic [11:0] pay);
    mk = '{ptype: pt, signalling: sv[1], vn_default: sv[0], virtual_network_tag: tag,
           concat_hdr: cf[2], frag: cf[1], frag_len: fl[13:3], frag_id: fl[2:0],
           ext_len: ext, pay_len: pay, pad_only: cf[0]};
  endfunction : mk

  task automatic pkt(input rlepe_desc_type d, input logic [1:0] lt, input logic om,
      input logic [3:0] ln, input logic [1:0] pn, input logic [23:0] pf, input logic drop);
    logic [13:0] tot;
    int          n;
    int          w;
    exq = {};
    rxq = {};
    n   = d.pad_only ? 0 : d.ext_len + d.pay_len;
    tot = 14'(pn + ln + n);
    if (!drop && !d.pad_only) begin
      if (d.frag) begin
        exq.push_back({3'b010, d.frag_len[10:5]});
        exq.push_back({1'b0, d.frag_len[4:0], d.frag_id});
        exq.push_back({1'b0, tot[12:5]});
      end else begin
        exq.push_back({3'b011, tot[10:5]});
      end
      exq.push_back({1'b0, tot[4:0], lt, om});
      for (int i = 0; i < ln; i++) exq.push_back({1'b0, i == 0 ? d.virtual_network_tag : 8'h00});
      for (int i = 0; i < pn; i++) exq.push_back({1'b0, pf[23-8*i -: 8]});
    end
    for (int i = 0; !drop && i < (d.pad_only ? int'(d.pay_len) : n); i++) begin
      exq.push_back({1'b0, d.pad_only ? 8'h00 : 8'ha0 + 8'(i)});
    end
    if (exq.size() > 0) exq[exq.size()-1][8] = 1'b1;
    desc       <= d;
    desc_valid <= 1'b1;
    @(posedge mclk);
    while (!desc_ready) @(posedge mclk);
    desc_valid <= 1'b0;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data  <= 8'ha0 + 8'(i);
      @(posedge mclk);
      while (!in_ready) @(posedge mclk);
    end
    in_valid <= 1'b0;
    w = 0;
    while ((rxq.size() < exq.size() || !desc_ready) && w < 400) begin
      @(posedge mclk);
      w++;
    end
    repeat (4) @(posedge mclk);
    chk(32'(rxq.size()), 32'(exq.size()));
    foreach (exq[i]) chk(32'(rxq[i]), 32'(exq[i]));
  endtask : pkt

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 32'h10);
    rd(8'h04, 32'h0800);
    rd(8'h1c, 32'h0);
    wr(8'h18, 32'h7);
    rd(8'h18, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'h1234);
    rd(8'h04, 32'h1234);
    wr(8'h04, 32'h0800);
    rd(8'h04, 32'h0800);
    $display("test registers done");
    wr(8'h00, 32'h11);
    rd(8'h00, 32'h11);
    pkt(mk(16'h0800, 2'b01, 8'h00, 3'h0, 14'h0, 12'h2, 12'h2),
        2'h2, 1'b1, 4'h0, 2'h0, 24'h0, 1'b0);
    pkt(mk(16'h0800, 2'b00, 8'h5a, 3'h0, 14'h0, 12'h0, 12'h3),
        2'h0, 1'b1, 4'h1, 2'h0, 24'h0, 1'b0);
    pkt(mk(16'h0082, 2'b10, 8'h00, 3'h0, 14'h0, 12'h0, 12'h2),
        2'h3, 1'b1, 4'h0, 2'h0, 24'h0, 1'b0);
    wr(8'h00, 32'h31);
    rd(8'h00, 32'h31);
    pkt(mk(16'h0800, 2'b00, 8'h5a, 3'h0, 14'h0, 12'h0, 12'h2),
        2'h0, 1'b0, 4'h3, 2'h2, 24'h080000, 1'b0);
    wr(8'h00, 32'h10);
    rd(8'h00, 32'h10);
    pkt(mk(16'h0800, 2'b01, 8'h00, 3'h0, 14'h0, 12'h0, 12'h2),
        2'h2, 1'b0, 4'h0, 2'h2, 24'h080000, 1'b0);
    wr(8'h08, 32'h011186dd);
    rd(8'h08, 32'h011186dd);
    wr(8'h00, 32'h12);
    rd(8'h00, 32'h12);
    pkt(mk(16'h86dd, 2'b01, 8'h00, 3'h0, 14'h0, 12'h0, 12'h1),
        2'h2, 1'b0, 4'h0, 2'h1, 24'h110000, 1'b0);
    pkt(mk(16'h1234, 2'b01, 8'h00, 3'h0, 14'h0, 12'h0, 12'h1),
        2'h2, 1'b0, 4'h0, 2'h3, 24'hff1234, 1'b0);
    pkt(mk(16'h0082, 2'b10, 8'h00, 3'h0, 14'h0, 12'h0, 12'h1),
        2'h3, 1'b0, 4'h0, 2'h1, 24'h420000, 1'b0);
    pkt(mk(16'h86dd, 2'b01, 8'h00, 3'h2, 14'h004d, 12'h0, 12'h4),
        2'h2, 1'b0, 4'h0, 2'h1, 24'h110000, 1'b0);
    pkt(mk(16'h0800, 2'b01, 8'h00, 3'h4, 14'h0, 12'h0, 12'h2),
        2'h2, 1'b0, 4'h0, 2'h1, 24'h0, 1'b1);
    wr(8'h00, 32'h14);
    rd(8'h00, 32'h14);
    pkt(mk(16'h0800, 2'b01, 8'h00, 3'h4, 14'h0, 12'h2, 12'h1),
        2'h2, 1'b0, 4'h0, 2'h2, 24'h080000, 1'b0);
    pkt(mk(16'h0800, 2'b01, 8'h00, 3'h2, 14'h0, 12'h2, 12'hffe),
        2'h2, 1'b0, 4'h0, 2'h2, 24'h0, 1'b1);
    rd(8'h20, 32'h2);
    $display("test coding done");
    slow  <= 1'b1;
    stall <= 1'b1;
    fork
      pkt(mk(16'h0800, 2'b01, 8'h00, 3'h0, 14'h0, 12'h0, 12'h14),
          2'h2, 1'b0, 4'h0, 2'h2, 24'h080000, 1'b0);
      begin
        repeat (60) @(posedge mclk);
        chk(32'(in_ready), 32'h0);
        stall <= 1'b0;
      end
    join
    slow <= 1'b0;
    rd(8'h1c, 32'hb);
    pkt(mk(16'h0000, 2'b00, 8'h00, 3'h1, 14'h0, 12'h0, 12'h3),
        2'h0, 1'b0, 4'h0, 2'h0, 24'h0, 1'b0);
    $display("test buffer and padding done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
